// [phsl_top.sv]
// strap capture at reset, mode resolution, led drive and wishbone registers
//
// Notes on behaviour
// [RULE1] transmit driver follows forced or negotiated speed
// [RULE2] receiver follows forced or negotiated speed
// [RULE3] board supplies 25 MHz reference, fifty ppm
// [RULE4] five address straps captured during reset
// [RULE5] strapped address zero isolates; written zero does not
// [RULE6] autoneg strap high: negotiate, advertise ability straps
// [RULE7] autoneg strap low: forced mode from ability straps
// [RULE8] autoneg and ability straps latched, then used
// [RULE9] straps sampled only while reset is active
// [RULE10] speed indicator high at 100, low at 10
// [RULE11] transmit indicator on during transmit activity
// [RULE12] receive indicator on during receive activity
// [RULE13] collision only in half duplex; duplex shows full
// [RULE14] link indicator on for valid link, either speed
// [RULE15] ability codes: 10h, 10f, 100h, 100f
// [RULE16] straps are inputs in reset, captured at release
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module phsl_top (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_arst_n,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// dual purpose address strap and led pins, bit order dplx col link tx rx
	input  wire logic [4:0]  i_mgmt_address_straps,
	output logic      [4:0]  o_mgmt_address_straps,
	output logic      [4:0]  o_mgmt_address_straps_oe,
	// mode straps
	input  wire logic        i_autoneg_strap,
	input  wire logic        i_ability_select_hi,
	input  wire logic        i_ability_select_lo,
	// speed led pin
	output logic             o_speed_indicator,
	// status from the line and negotiation logic
	input  wire logic        i_link_up,
	input  wire logic        i_tx_active,
	input  wire logic        i_rx_active,
	input  wire logic        i_col_detect,
	input  wire logic        i_an_done,
	input  wire logic        i_an_speed100,
	input  wire logic        i_an_full,
	// configuration to the line and negotiation logic
	output logic             o_line_tx_100,
	output logic             o_line_rx_100,
	output logic             o_full_duplex,
	output logic             o_an_enable,
	output logic      [3:0]  o_an_advertise,
	output logic             o_mii_isolate,
	output logic      [4:0]  o_mgmt_address
);

	// reset release synchroniser
	logic                rst_meta_r;   // first stage, read only by second
	logic                rst_done_r;   // high once reset is fully released
	// strap synchroniser and capture
	phsl_pkg::phsl_strap_t strap_meta_r; // first stage
	phsl_pkg::phsl_strap_t strap_sync_r; // second stage
	phsl_pkg::phsl_strap_t strap_r;      // latched strap values
	// config register
	logic [4:0]          cfg_addr_r;   // software management address
	logic                cfg_led_en_r; // led drive enable
	logic                cfg_addr_sel_r; // use software address
	// resolved mode
	phsl_pkg::phsl_mode_t mode_nxt;
	phsl_pkg::phsl_led_t  led_nxt;
	logic [3:0]          adv_nxt;
	// bus
	logic                wb_req;
	logic                wb_wr;
	logic [31:0]         rd_nxt;
	// read word images, one per register
	logic [31:0]         strap_word;
	logic [31:0]         cfg_word;
	logic [31:0]         link_word;

	// speed and duplex carried by a forced ability code
	function automatic phsl_pkg::phsl_mode_t phsl_forced(
		input logic [1:0] abil
	);
		phsl_pkg::phsl_mode_t m;
		// link is left low here; the caller fills it from the line
		m.link = 1'b0;
		m.speed100 = 1'b0;
		m.full = 1'b0;
		unique case (abil)
			// ten megabit, half duplex
			phsl_pkg::PHSL_AB_10_HALF: begin // [RULE15]
				m.speed100 = 1'b0;
				m.full = 1'b0;
			end
			// ten megabit, full duplex
			phsl_pkg::PHSL_AB_10_FULL: begin // [RULE15]
				m.speed100 = 1'b0;
				m.full = 1'b1;
			end
			// hundred megabit, half duplex
			phsl_pkg::PHSL_AB_100_HALF: begin // [RULE15]
				m.speed100 = 1'b1;
				m.full = 1'b0;
			end
			// hundred megabit, full duplex
			phsl_pkg::PHSL_AB_100_FULL: begin // [RULE15]
				m.speed100 = 1'b1;
				m.full = 1'b1;
			end
		endcase
		return m;
	endfunction

	// abilities advertised for an ability code when negotiating
	function automatic logic [3:0] phsl_advert(input logic [1:0] abil);
		logic [3:0] a;
		// default keeps every path assigned; each code has its own arm
		a = phsl_pkg::PHSL_ADV_ALL;
		// the forced code names are reused: same two strap bits
		unique case (abil)
			// code 00: ten megabit, half and full
			phsl_pkg::PHSL_AB_10_HALF: begin
				a = phsl_pkg::PHSL_ADV_10_BOTH; // [RULE6]
			end
			// code 01: hundred megabit, half and full
			phsl_pkg::PHSL_AB_10_FULL: begin
				a = phsl_pkg::PHSL_ADV_100_BOTH; // [RULE6]
			end
			// code 10: half duplex at both speeds
			phsl_pkg::PHSL_AB_100_HALF: begin
				a = phsl_pkg::PHSL_ADV_HALF; // [RULE6]
			end
			// code 11: every ability
			phsl_pkg::PHSL_AB_100_FULL: begin
				a = phsl_pkg::PHSL_ADV_ALL; // [RULE6]
			end
		endcase
		return a;
	endfunction

	// reset release: asserts at once, releases after two edges
	// so no flop leaves reset on a different edge from its neighbours;
	// the released level is a constant, never a pin
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_r <= 1'b0;
			rst_done_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_done_r <= rst_meta_r;
		end
	end

	// pin synchroniser for all straps; no reset, data path only
	// strap pins have no relation to the clock, so two stages keep
	// a metastable level away from the capture register
	always_ff @(posedge i_ref_clk) begin
		strap_meta_r.addr  <= i_mgmt_address_straps;
		strap_meta_r.autoneg_strap <= i_autoneg_strap;
		strap_meta_r.abil  <= {i_ability_select_hi, i_ability_select_lo};
		// second stage: the only reader of the first
		strap_sync_r       <= strap_meta_r;
	end

	// capture follows the pins only until release completes, so the
	// last value kept is the one seen as reset went away
	always_ff @(posedge i_ref_clk) begin
		// no reset: the pins themselves give the value during reset
		if (!rst_done_r) begin
			// still the input phase: follow the synchronised pins
			strap_r <= strap_sync_r; // [RULE4] [RULE8] [RULE9] [RULE16]
		end
	end

	// pins stay inputs through reset and turn to led outputs after
	// the handover waits for the capture to close, so no pin is
	// driven while its strap level is still being read
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mgmt_address_straps_oe <= 5'h00; // [RULE16]
		end else begin
			// all five pins turn together
			o_mgmt_address_straps_oe <= {5{rst_done_r}}; // [RULE9]
		end
	end

	// operating mode: negotiated result or forced strap code
	always_comb begin
		if (strap_r.autoneg_strap) begin
			// negotiating: speed and duplex come from the result
			mode_nxt.speed100 = i_an_speed100; // [RULE6]
			mode_nxt.full = i_an_full;
			// a link only counts once negotiation has finished
			mode_nxt.link = i_link_up & i_an_done;
		end else begin
			// forced: the latched ability code alone decides
			mode_nxt = phsl_forced(strap_r.abil); // [RULE7]
			mode_nxt.link = i_link_up;
		end
		// nothing is advertised in forced mode
		adv_nxt = strap_r.autoneg_strap ? phsl_advert(strap_r.abil) : 4'h0; // [RULE6]
	end

	// led pattern from status; collision masked in full duplex
	always_comb begin
		// duplex led shows resolved duplex whether or not a link is up
		led_nxt.dplx = mode_nxt.full; // [RULE13]
		led_nxt.col  = i_col_detect & ~mode_nxt.full; // [RULE13]
		led_nxt.link = mode_nxt.link; // [RULE14]
		led_nxt.tx   = i_tx_active; // [RULE11]
		led_nxt.rx   = i_rx_active; // [RULE12]
		// software can blank every led at once
		if (!cfg_led_en_r) begin
			led_nxt = '0;
		end
	end

	// line configuration and mode outputs, held idle in reset
	// until release completes they keep 10 Mb/s half duplex, so the
	// line never starts in a mode that the straps did not ask for
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_line_tx_100  <= 1'b0;
			o_line_rx_100  <= 1'b0;
			o_full_duplex  <= 1'b0;
			o_an_enable    <= 1'b0;
			o_an_advertise <= 4'h0;
		end else if (rst_done_r) begin
			o_line_tx_100  <= mode_nxt.speed100; // [RULE1]
			o_line_rx_100  <= mode_nxt.speed100; // [RULE2]
			o_full_duplex  <= mode_nxt.full;
			o_an_enable    <= strap_r.autoneg_strap; // [RULE6] [RULE7]
			o_an_advertise <= adv_nxt; // [RULE6]
		end
	end

	// led pins and speed indicator
	// the pin values change on the same edge as the enables rise, so
	// the board never sees a stale pattern at the handover
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mgmt_address_straps <= 5'h00;
			o_speed_indicator     <= 1'b0;
		end else if (rst_done_r) begin
			o_mgmt_address_straps <= {led_nxt.rx, led_nxt.tx,
				led_nxt.link, led_nxt.col, led_nxt.dplx};
			o_speed_indicator <= cfg_led_en_r & mode_nxt.speed100; // [RULE10]
		end
	end

	// isolation only from the strapped address, never the written one
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mii_isolate  <= 1'b0;
			o_mgmt_address <= 5'h00;
		end else if (rst_done_r) begin
			// compare the captured straps only, never the config register
			o_mii_isolate <=
				(strap_r.addr == phsl_pkg::PHSL_ISO_ADDR); // [RULE5]
			// the written address only steers the management address
			o_mgmt_address <= cfg_addr_sel_r ? cfg_addr_r : strap_r.addr;
		end
	end

	// bus request decode; write lands on the acknowledging edge
	// gating the write with ack makes it land once per request, on
	// the edge where the master sees the answer
	assign wb_req = i_wb_cyc & i_wb_stb;
	assign wb_wr  = wb_req & i_wb_we & o_wb_ack;

	// config register writes, byte lane 0 address, lane 1 flags
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_addr_r     <= phsl_pkg::PHSL_CF_ADDR_RST;
			cfg_led_en_r   <= phsl_pkg::PHSL_CF_LED_EN_RST;
			cfg_addr_sel_r <= phsl_pkg::PHSL_CF_ADDR_SEL_RST;
		end else if (wb_wr && i_wb_adr == phsl_pkg::PHSL_OFS_CONFIG) begin
			// lane 0: software management address
			if (i_wb_sel[0]) begin
				cfg_addr_r <= i_wb_dat[phsl_pkg::PHSL_CF_ADDR_LSB +: 5];
			end
			// lane 1: led enable and address select
			if (i_wb_sel[1]) begin
				cfg_led_en_r   <= i_wb_dat[phsl_pkg::PHSL_CF_LED_EN];
				cfg_addr_sel_r <= i_wb_dat[phsl_pkg::PHSL_CF_ADDR_SEL];
			end
		end
	end

	// read words, assembled every cycle and picked by the address,
	// so the answer needs no wait state
	always_comb begin
		// strap status: captured values and the isolate flag
		strap_word = 32'h0;
		strap_word[phsl_pkg::PHSL_ST_ADDR_LSB +: 5] = strap_r.addr;
		strap_word[phsl_pkg::PHSL_ST_AUTONEG_STRAP] = strap_r.autoneg_strap;
		strap_word[phsl_pkg::PHSL_ST_ABIL_LSB +: 2] = strap_r.abil;
		strap_word[phsl_pkg::PHSL_ST_ISOLATE] = o_mii_isolate;
		// config: the software fields
		cfg_word = 32'h0;
		cfg_word[phsl_pkg::PHSL_CF_ADDR_LSB +: 5] = cfg_addr_r;
		cfg_word[phsl_pkg::PHSL_CF_LED_EN] = cfg_led_en_r;
		cfg_word[phsl_pkg::PHSL_CF_ADDR_SEL] = cfg_addr_sel_r;
		// link status: live levels, collision shown raw
		link_word = 32'h0;
		link_word[phsl_pkg::PHSL_LK_LINK] = mode_nxt.link;
		link_word[phsl_pkg::PHSL_LK_SPEED] = mode_nxt.speed100;
		link_word[phsl_pkg::PHSL_LK_FULL] = mode_nxt.full;
		link_word[phsl_pkg::PHSL_LK_TX] = i_tx_active;
		link_word[phsl_pkg::PHSL_LK_RX] = i_rx_active;
		link_word[phsl_pkg::PHSL_LK_COL] = i_col_detect;
		link_word[phsl_pkg::PHSL_LK_AN_DONE] = i_an_done;
		// unmapped offsets read as zero
		unique case (i_wb_adr)
			phsl_pkg::PHSL_OFS_STRAP:  rd_nxt = strap_word;
			phsl_pkg::PHSL_OFS_CONFIG: rd_nxt = cfg_word;
			phsl_pkg::PHSL_OFS_LINK:   rd_nxt = link_word;
			default:                   rd_nxt = 32'h0;
		endcase
	end

	// one-cycle acknowledge, dropped the cycle after it is given
	// a request held through its ack is not taken twice: ack gates it
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= wb_req & ~o_wb_ack;
			// read data loads as the request is taken, holds until the next
			if (wb_req && !o_wb_ack) begin
				o_wb_dat <= rd_nxt;
			end
		end
	end

endmodule

// [phsl_pkg.sv]
// shared constants and carrier types for strap capture and led status
package phsl_pkg;
	// register byte offsets
	localparam logic [7:0] PHSL_OFS_STRAP  = 8'h00;
	localparam logic [7:0] PHSL_OFS_CONFIG = 8'h04;
	localparam logic [7:0] PHSL_OFS_LINK   = 8'h08;
	// strap status field positions
	localparam int PHSL_ST_ADDR_LSB = 0;
	localparam int PHSL_ST_AUTONEG_STRAP    = 5;
	localparam int PHSL_ST_ABIL_LSB = 6;
	localparam int PHSL_ST_ISOLATE  = 8;
	// config field positions and reset values
	localparam int PHSL_CF_ADDR_LSB = 0;
	localparam int PHSL_CF_LED_EN   = 8;
	localparam int PHSL_CF_ADDR_SEL = 9;
	localparam logic [4:0] PHSL_CF_ADDR_RST = 5'h00;
	localparam logic PHSL_CF_LED_EN_RST   = 1'b1;
	localparam logic PHSL_CF_ADDR_SEL_RST = 1'b0;
	// link status field positions
	localparam int PHSL_LK_LINK    = 0;
	localparam int PHSL_LK_SPEED   = 1;
	localparam int PHSL_LK_FULL    = 2;
	localparam int PHSL_LK_TX      = 3;
	localparam int PHSL_LK_RX      = 4;
	localparam int PHSL_LK_COL     = 5;
	localparam int PHSL_LK_AN_DONE = 6;
	// ability strap codes
	localparam logic [1:0] PHSL_AB_10_HALF  = 2'h0;
	localparam logic [1:0] PHSL_AB_10_FULL  = 2'h1;
	localparam logic [1:0] PHSL_AB_100_HALF = 2'h2;
	localparam logic [1:0] PHSL_AB_100_FULL = 2'h3;
	// advertised ability bits {100 full, 100 half, 10 full, 10 half}
	localparam logic [3:0] PHSL_ADV_10_BOTH  = 4'h3;
	localparam logic [3:0] PHSL_ADV_100_BOTH = 4'hc;
	localparam logic [3:0] PHSL_ADV_HALF     = 4'h5;
	localparam logic [3:0] PHSL_ADV_ALL      = 4'hf;
	// isolating management address
	localparam logic [4:0] PHSL_ISO_ADDR = 5'h00;
	// latched strap values
	typedef struct packed {
		logic [4:0] addr;
		logic       autoneg_strap;
		logic [1:0] abil;
	} phsl_strap_t;
	// resolved operating mode
	typedef struct packed {
		logic link;
		logic speed100;
		logic full;
	} phsl_mode_t;
	// led pin group
	typedef struct packed {
		logic rx;
		logic tx;
		logic link;
		logic col;
		logic dplx;
	} phsl_led_t;
endpackage

// [phsl_top_assertions.sv]
// checker for strap capture, mode and led pin outputs
`timescale 1ns/1ps
module phsl_chk (
	// clock and reset
	input wire logic       i_ref_clk,
	input wire logic       i_arst_n,
	// status inputs
	input wire logic       i_link_up,
	input wire logic       i_tx_active,
	input wire logic       i_rx_active,
	input wire logic       i_col_detect,
	input wire logic       i_an_done,
	input wire logic       i_an_speed100,
	// watched outputs
	input wire logic [4:0] o_mgmt_address_straps,
	input wire logic [4:0] o_mgmt_address_straps_oe,
	input wire logic       o_speed_indicator,
	input wire logic       o_line_tx_100,
	input wire logic       o_line_rx_100,
	input wire logic       o_an_enable,
	input wire logic [3:0] o_an_advertise,
	input wire logic       o_mii_isolate
);
	logic [4:0] led; // led levels {rx,tx,link,col,dplx}
	logic       run; // pins handed over to led duty
	assign led = o_mgmt_address_straps;
	assign run = o_mgmt_address_straps_oe[0];
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	a_pins_driven: assert property (run |-> o_mgmt_address_straps_oe == 5'h1f)
		else $error("pins only partly driven");
	a_tx_rx_same: assert property (run |-> o_line_tx_100 == o_line_rx_100)
		else $error("line speeds differ");
	a_rx_an_speed: assert property ($past(run) && o_an_enable && $past(i_an_done)
		|-> o_line_rx_100 == $past(i_an_speed100)) else $error("rx speed wrong");
	a_speed_led: assert property ($past(run) && o_speed_indicator |-> o_line_tx_100)
		else $error("speed led without 100");
	a_forced_adv: assert property (run && !o_an_enable |-> o_an_advertise == 4'h0)
		else $error("forced mode advertises");
	a_mode_held: assert property ($past(run) |-> $stable(o_an_enable) && $stable(o_an_advertise))
		else $error("latched mode changed");
	a_isolate_held: assert property ($past(run) |-> $stable(o_mii_isolate))
		else $error("isolate changed");
	a_tx_led: assert property ($past(run) && led[3] |-> $past(i_tx_active))
		else $error("tx led without activity");
	a_rx_led: assert property ($past(run) && led[4] |-> $past(i_rx_active))
		else $error("rx led without activity");
	a_col_half: assert property (led[1] |-> !led[0] && $past(i_col_detect))
		else $error("collision led wrong");
	a_link_led: assert property (led[2] |-> $past(i_link_up))
		else $error("link led without link");
	// main scenarios reached
	c_isolate: cover property (o_mii_isolate);
	c_an_fast: cover property (o_an_enable && o_line_tx_100);
	c_col_led: cover property (led[1]);
endmodule
bind phsl_top phsl_chk i_chk (
	.i_ref_clk               (i_ref_clk),
	.i_arst_n                (i_arst_n),
	.i_link_up               (i_link_up),
	.i_tx_active             (i_tx_active),
	.i_rx_active             (i_rx_active),
	.i_col_detect            (i_col_detect),
	.i_an_done               (i_an_done),
	.i_an_speed100           (i_an_speed100),
	.o_mgmt_address_straps   (o_mgmt_address_straps),
	.o_mgmt_address_straps_oe(o_mgmt_address_straps_oe),
	.o_speed_indicator       (o_speed_indicator),
	.o_line_tx_100           (o_line_tx_100),
	.o_line_rx_100           (o_line_rx_100),
	.o_an_enable             (o_an_enable),
	.o_an_advertise          (o_an_advertise),
	.o_mii_isolate           (o_mii_isolate)
);

// [phsl_board.sv]
// board model: strap resistors on the pins and led loads
`timescale 1ns/1ps
module phsl_board (
	// strap settings
	input  wire logic [4:0] i_addr,
	input  wire logic       i_an,
	input  wire logic [1:0] i_abil,
	// design side of the dual purpose pins
	input  wire logic [4:0] i_led,
	input  wire logic [4:0] i_oe,
	// pin levels
	output logic      [4:0] o_pin,
	output logic            o_an,
	output logic            o_hi,
	output logic            o_lo
);
	// resistor sets the level wherever the design does not drive
	always_comb begin
		for (int b = 0; b < 5; b++) o_pin[b] = i_oe[b] ? i_led[b] : i_addr[b];
	end
	// mode straps are plain resistors
	assign o_an = i_an;
	assign o_hi = i_abil[1];
	assign o_lo = i_abil[0];
endmodule

// [phy_strap_and_led_status_tb.sv]
// self-checking bench for strap capture and led status
`timescale 1ns/1ps
module phy_strap_and_led_status_tb;
	logic clk = 1'b0, rst_n = 1'b0; // clock and reset
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus controls
	logic [7:0] adr = 8'h00; // bus address
	logic [31:0] wdat = 32'h0, rdat, q; // bus data
	logic ack; // bus answer
	logic lnk = 1'b1, tx = 1'b0, rx = 1'b0, col = 1'b0; // line status
	logic adn = 1'b0, asp = 1'b0, afu = 1'b0; // negotiation status
	logic [4:0] s_addr = 5'h00, led, oe, pin, maddr; // straps and pins
	logic s_an = 1'b0, an_p, hi_p, lo_p; // mode straps
	logic [1:0] s_ab = 2'h0; // ability straps
	logic spd, tx100, rx100, full, autoneg_strap, iso; // mode outputs
	logic [3:0] adv; // advertised abilities
	int errors = 0, n_compared = 0, cycles = 0;
	localparam logic [3:0] ADV [4] = '{4'h3, 4'hc, 4'h5, 4'hf};
	always #5 clk = ~clk; // 100 MHz stand-in for the reference
	phsl_board i_board (.i_addr(s_addr), .i_an(s_an), .i_abil(s_ab), .i_led(led),
		.i_oe(oe), .o_pin(pin), .o_an(an_p), .o_hi(hi_p), .o_lo(lo_p));
	phsl_top i_dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h3), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_mgmt_address_straps(pin), .o_mgmt_address_straps(led),
		.o_mgmt_address_straps_oe(oe), .i_autoneg_strap(an_p), .i_ability_select_hi(hi_p),
		.i_ability_select_lo(lo_p), .o_speed_indicator(spd), .i_link_up(lnk),
		.i_tx_active(tx), .i_rx_active(rx), .i_col_detect(col), .i_an_done(adn),
		.i_an_speed100(asp), .i_an_full(afu), .o_line_tx_100(tx100),
		.o_line_rx_100(rx100), .o_full_duplex(full), .o_an_enable(autoneg_strap),
		.o_an_advertise(adv), .o_mii_isolate(iso), .o_mgmt_address(maddr));
	// compare one result
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// let status changes reach the pins
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// reset with the given straps held stable
	task automatic rst(input logic [4:0] a, input logic n, input logic [1:0] b);
		@(posedge clk);
		rst_n <= 1'b0;
		s_addr <= a;
		s_an <= n;
		s_ab <= b;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask
	// one classic bus cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0; // edges until the answer is seen
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk(n, 2); // ack one cycle after the request is taken
		#1;
	endtask
	// every forced code
	task automatic t_forced;
		for (int c = 0; c < 4; c++) begin
			rst(5'h05, 1'b0, c[1:0]);
			chk({autoneg_strap, adv}, 5'h00);
			chk(tx100, c[1]);
			chk(rx100, c[1]);
			chk(full, c[0]);
			chk(spd, c[1]);
		end
		$display("forced mode test done");
	endtask
	// every advertised code, negotiated speed
	task automatic t_autoneg;
		for (int c = 0; c < 4; c++) begin
			rst(5'h05, 1'b1, c[1:0]);
			chk({autoneg_strap, adv}, {1'b1, ADV[c]});
			@(posedge clk);
			asp <= c[0];
			afu <= c[1];
			adn <= 1'b1;
			settle;
			chk(tx100, c[0]);
			chk(rx100, c[0]);
			chk(full, c[1]);
			chk(pin, 5'h04 | c[1]);
		end
		@(posedge clk);
		adn <= 1'b0;
		$display("negotiation test done");
	endtask
	// address capture, isolation, late strap changes
	task automatic t_address;
		rst(5'h1f, 1'b1, 2'h2);
		wb(1'b0, 8'h00, 32'h0);
		chk(q, 32'hbf);
		chk({iso, maddr}, 6'h1f);
		@(posedge clk);
		s_an <= 1'b0;
		s_ab <= 2'h1;
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b1, 8'h04, 32'h200);
		wb(1'b0, 8'h00, 32'h0);
		chk(q, 32'hbf);
		chk(adv, 4'h5);
		chk({iso, maddr}, 6'h00);
		wb(1'b0, 8'h0c, 32'h0);
		chk(q, 32'h0);
		rst(5'h00, 1'b0, 2'h0);
		chk(iso, 1'b1);
		wb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h100);
		$display("address test done");
	endtask
	// led pins in half and full duplex, then disabled
	task automatic t_leds;
		rst(5'h0a, 1'b0, 2'h0);
		@(posedge clk);
		tx <= 1'b1;
		col <= 1'b1;
		settle;
		chk(oe, 5'h1f);
		chk(pin, 5'h0e);
		wb(1'b0, 8'h08, 32'h0);
		chk(q, 32'h29);
		@(posedge clk);
		{lnk, tx, rx, col} <= 4'h2;
		settle;
		chk(pin, 5'h10);
		rst(5'h0a, 1'b0, 2'h3);
		@(posedge clk);
		{lnk, rx, col} <= 3'h5;
		settle;
		chk(pin, 5'h05);
		chk(spd, 1'b1);
		wb(1'b1, 8'h04, 32'h0);
		settle;
		chk({spd, pin}, 6'h00);
		@(posedge clk);
		col <= 1'b0;
		$display("led test done");
	endtask
	// verdict and end of run
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			end_of_test;
		end
	end
	initial begin
		t_forced;
		t_autoneg;
		t_address;
		t_leds;
		end_of_test;
	end
endmodule
